/* uep_device.sv */
// Purpose: Endpoint FIFOs, byte counts and endpoint zero control flags
// Assumes: Firmware port strobes are one-cycle, synchronous to pclk
// Notes: Read data appears one cycle after the read strobe
// Behaviour
// - Byte-wide data port per endpoint FIFO
// - Byte count includes two CRC bytes
// - EP3/EP4 eight bytes, EP1/EP2 sixty-four
// - Count seven bits EP1/2, six otherwise
// - Reserved bits read zero, ignore writes
// - Stall-sent flag set after STALL handshake
// - SETUP sets bit 2, clears others
// - Setup flag interrupts; acknowledge clears it
// - OUT data sets flag; NAK meanwhile
// - No FIFO overwrite except early SETUP
// - OUT flag for data and status stages
// - OUT flag interrupts; acknowledge clears it
// - IN-done on data or status completion
// - IN-done read-only, cleared by acknowledge
// - Direction bit picks status phase direction
// - Last-packet with loaded leads to status
// - Force-halt answers EP0 IN and OUT tokens with STALL
// - Firmware sets force-halt when needed
// - Loaded bit cleared on host ACK
// - Firmware loads FIFO only when unloaded
// - Unloaded plus last sends DATA1 status
// - Loaded cleared with IN-done interrupts
// - Acknowledge ones clear flags, not stored
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uep_device
  import uep_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to host
  uep_link_if.dev lk,
  // Firmware register port
  input wire logic [12:0] fw_addr,
  input wire logic fw_wr,
  input wire logic fw_rd,
  input wire logic [7:0] fw_wdata,
  output logic [7:0] fw_rdata,
  // Interrupt
  input wire logic irq_en,
  output logic irq
);
  typedef enum {L_IDLE, L_RX, L_TX, L_WAIT} uep_lstate_t;

  // FIFO size per endpoint, as an index mask
  function automatic logic [5:0] depth_mask(input logic [2:0] ep);
    depth_mask = (ep == 3'h1 || ep == 3'h2) ? DEPTH_MASK_BIG : DEPTH_MASK_SMALL;
  endfunction : depth_mask

  // Writable count bits per endpoint
  function automatic logic [6:0] cnt_mask(input logic [2:0] ep);
    cnt_mask = (ep == 3'h1 || ep == 3'h2) ? CNT_MASK_BIG : CNT_MASK_SMALL;
  endfunction : cnt_mask

  // Address decode of data ports and counts: {hit, endpoint}
  function automatic logic [3:0] decode(input logic [12:0] a, input logic data);
    decode = 4'h0;
    if (a == (data ? ADDR_DATA0 : ADDR_CNT0)) decode = 4'h8;
    if (a == (data ? ADDR_DATA1 : ADDR_CNT1)) decode = 4'h9;
    if (a == (data ? ADDR_DATA2 : ADDR_CNT2)) decode = 4'hA;
    if (a == (data ? ADDR_DATA3 : ADDR_CNT3)) decode = 4'hB;
    if (a == (data ? ADDR_DATA4 : ADDR_CNT4)) decode = 4'hC;
  endfunction : decode

  logic [7:0] mem [0:4][0:63]; // Endpoint FIFO storage
  logic [6:0] cnt_reg [0:4]; // Byte counts, CRC included
  logic [5:0] ptr_reg [0:4]; // Firmware FIFO pointers
  uep_lstate_t state_reg; // Link sequencer
  logic [2:0] ep_reg; // Endpoint of current token
  uep_tok_t kind_reg; // Kind of current token
  logic keep_reg; // Store incoming bytes
  uep_hs_t ans_reg; // Handshake after data
  logic [6:0] rxn_reg; // Bytes received
  logic [6:0] txi_reg; // Transmit index
  logic [6:0] txn_reg; // Transmit length
  logic zlp_reg; // Current IN is status zero-length
  logic tog_reg; // EP0 data toggle
  logic hs_valid_reg, tx_valid_reg, tx_end_reg, tx_data1_reg;
  uep_hs_t hs_code_reg;
  logic [7:0] tx_byte_reg;
  // EP0 status and control
  logic st_stall_reg, st_setup_reg, st_out_reg, st_done_reg;
  logic ct_dir_reg, ct_last_reg, ct_fstall_reg, ct_loaded_reg;
  logic [7:0] fw_rdata_reg;
  logic irq_reg;

  // Events and decodes
  logic [3:0] dp_hit, cn_hit;
  logic ctl_wr, rx_end, rx_ok, acked, setup_ev;
  always_comb
  begin
    dp_hit = decode(fw_addr, 1'b1);
    cn_hit = decode(fw_addr, 1'b0);
    ctl_wr = fw_wr && fw_addr == ADDR_EP0_STAT_CTRL;
    rx_end = state_reg == L_RX && lk.dat_end;
    rx_ok = rx_end && keep_reg;
    acked = state_reg == L_WAIT && lk.hack_valid && lk.hack_ok;
    setup_ev = rx_ok && kind_reg == TOK_SETUP && ep_reg == 3'h0;
  end

  // Link sequencer: tokens, data and handshakes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= L_IDLE;
      ep_reg <= 3'h0;
      kind_reg <= TOK_SETUP;
      keep_reg <= 1'b0;
      ans_reg <= HS_ACK;
      rxn_reg <= 7'h00;
      txi_reg <= 7'h00;
      txn_reg <= 7'h00;
      zlp_reg <= 1'b0;
      hs_valid_reg <= 1'b0;
      hs_code_reg <= HS_ACK;
      tx_valid_reg <= 1'b0;
      tx_end_reg <= 1'b0;
      tx_data1_reg <= 1'b0;
      tx_byte_reg <= RESET_BYTE;
    end
    else
    begin
      hs_valid_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_end_reg <= 1'b0;
      case (state_reg)
        L_IDLE:
        begin
          if (lk.tok_valid)
          begin
            ep_reg <= lk.tok_ep;
            kind_reg <= lk.tok_kind;
            rxn_reg <= 7'h00;
            txi_reg <= 7'h00;
            zlp_reg <= 1'b0;
            if (lk.tok_kind != TOK_IN)
            begin
              // Early SETUP may replace the FIFO
              state_reg <= L_RX;
              if (lk.tok_kind == TOK_SETUP)
              begin
                keep_reg <= 1'b1;
                ans_reg <= HS_ACK;
              end
              else if (lk.tok_ep == 3'h0 && ct_fstall_reg)
              begin
                keep_reg <= 1'b0;
                ans_reg <= HS_STALL;
              end
              else if (lk.tok_ep == 3'h0 && st_out_reg)
              begin
                keep_reg <= 1'b0;
                ans_reg <= HS_NAK;
              end
              else
              begin
                keep_reg <= 1'b1;
                ans_reg <= HS_ACK;
              end
            end
            else if (lk.tok_ep == 3'h0 && ct_fstall_reg)
            begin
              hs_valid_reg <= 1'b1;
              hs_code_reg <= HS_STALL;
            end
            else if (lk.tok_ep != 3'h0 || ct_loaded_reg)
            begin
              // Payload is count less CRC
              state_reg <= L_TX;
              txn_reg <= (cnt_reg[lk.tok_ep] >= CRC_BYTES) ?
                cnt_reg[lk.tok_ep] - CRC_BYTES : 7'h00;
              tx_data1_reg <= (lk.tok_ep == 3'h0) ? tog_reg : 1'b0;
            end
            else if (ct_last_reg && !ct_dir_reg)
            begin
              // Status stage: zero-length DATA1
              state_reg <= L_TX;
              txn_reg <= 7'h00;
              zlp_reg <= 1'b1;
              tx_data1_reg <= 1'b1;
            end
            else
            begin
              hs_valid_reg <= 1'b1;
              hs_code_reg <= HS_NAK;
            end
          end
        end
        L_RX:
        begin
          if (lk.dat_valid && keep_reg && rxn_reg <= {1'b0, depth_mask(ep_reg)})
            rxn_reg <= rxn_reg + 7'h01;
          if (lk.dat_end)
          begin
            hs_valid_reg <= 1'b1;
            hs_code_reg <= ans_reg;
            state_reg <= L_IDLE;
          end
        end
        L_TX:
        begin
          // One byte a cycle, then the end strobe
          if (txi_reg == txn_reg)
          begin
            tx_end_reg <= 1'b1;
            state_reg <= L_WAIT;
          end
          else
          begin
            tx_valid_reg <= 1'b1;
            tx_byte_reg <= mem[ep_reg][txi_reg[5:0] & depth_mask(ep_reg)];
            txi_reg <= txi_reg + 7'h01;
          end
        end
        L_WAIT:
        begin
          // A refused packet waits for the next IN token
          if (lk.hack_valid)
            state_reg <= L_IDLE;
        end
        default: state_reg <= L_IDLE;
      endcase
    end
  end

  // FIFO storage: link writes and firmware writes
  always_ff @(posedge pclk)
  begin
    if (state_reg == L_RX && lk.dat_valid && keep_reg && rxn_reg <= {1'b0, depth_mask(ep_reg)})
      mem[ep_reg][rxn_reg[5:0]] <= lk.dat_byte;
    if (fw_wr && dp_hit[3])
      mem[dp_hit[2:0]][ptr_reg[dp_hit[2:0]]] <= fw_wdata;
  end

  // Byte counts: received length plus CRC, or firmware value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 5; i++)
        cnt_reg[i] <= 7'h00;
    end
    else if (rx_ok)
      cnt_reg[ep_reg] <= (rxn_reg + CRC_BYTES) & cnt_mask(ep_reg);
    else if (fw_wr && cn_hit[3])
      cnt_reg[cn_hit[2:0]] <= fw_wdata[6:0] & cnt_mask(cn_hit[2:0]);
  end

  // Firmware FIFO pointers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 5; i++)
        ptr_reg[i] <= 6'h00;
    end
    else
    begin
      if ((fw_wr || fw_rd) && dp_hit[3])
        ptr_reg[dp_hit[2:0]] <= (ptr_reg[dp_hit[2:0]] + 6'h01) & depth_mask(dp_hit[2:0]);
      // Rewind on a new packet, received or loaded
      if (rx_ok)
        ptr_reg[ep_reg] <= 6'h00;
      if (ctl_wr && fw_wdata[BIT_LOADED])
        ptr_reg[0] <= 6'h00;
      if (fw_wr && cn_hit[3] && cn_hit[2:0] != 3'h0)
        ptr_reg[cn_hit[2:0]] <= 6'h00;
    end
  end

  // EP0 status flags; hardware set wins over acknowledge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_stall_reg <= 1'b0;
      st_setup_reg <= 1'b0;
      st_out_reg <= 1'b0;
      st_done_reg <= 1'b0;
    end
    else if (setup_ev)
    begin
      st_setup_reg <= 1'b1;
      st_stall_reg <= 1'b0;
      st_out_reg <= 1'b0;
      st_done_reg <= 1'b0;
    end
    else
    begin
      st_stall_reg <= (st_stall_reg && !(ctl_wr && fw_wdata[BIT_STALL_SENT]))
        || (hs_valid_reg && hs_code_reg == HS_STALL);
      st_setup_reg <= st_setup_reg && !(ctl_wr && fw_wdata[BIT_SETUP]);
      st_out_reg <= (st_out_reg && !(ctl_wr && fw_wdata[BIT_RX_OUT]))
        || (rx_ok && ep_reg == 3'h0);
      st_done_reg <= (st_done_reg && !(ctl_wr && fw_wdata[BIT_IN_DONE]))
        || (acked && ep_reg == 3'h0);
    end
  end

  // EP0 control bits; acknowledge bits are never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ct_dir_reg <= 1'b0;
      ct_last_reg <= 1'b0;
      ct_fstall_reg <= 1'b0;
      ct_loaded_reg <= 1'b0;
    end
    else if (ctl_wr)
    begin
      ct_dir_reg <= fw_wdata[BIT_DIR];
      ct_last_reg <= fw_wdata[BIT_LAST];
      ct_fstall_reg <= fw_wdata[BIT_FSTALL];
      ct_loaded_reg <= fw_wdata[BIT_LOADED];
    end
    else if (acked && ep_reg == 3'h0 && !zlp_reg)
      ct_loaded_reg <= 1'b0;
  end

  // EP0 data toggle: DATA1 after SETUP, flips on each host ACK of IN data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tog_reg <= 1'b0;
    else if (setup_ev)
      tog_reg <= 1'b1;
    else if (acked && ep_reg == 3'h0 && !zlp_reg)
      tog_reg <= !tog_reg;
  end

  // Firmware read data; reserved bits and unmapped reads give zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fw_rdata_reg <= 8'h00;
    else if (fw_rd)
    begin
      if (dp_hit[3])
        fw_rdata_reg <= mem[dp_hit[2:0]][ptr_reg[dp_hit[2:0]]];
      else if (cn_hit[3])
        fw_rdata_reg <= {1'b0, cnt_reg[cn_hit[2:0]]};
      else if (fw_addr == ADDR_EP0_STAT_CTRL)
        fw_rdata_reg <= {4'h0, st_stall_reg, st_setup_reg, st_out_reg, st_done_reg};
      else
        fw_rdata_reg <= 8'h00;
    end
  end

  // Interrupt request level; IN-done rises as loaded falls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_en && (st_setup_reg || st_out_reg || st_done_reg || st_stall_reg);
  end

  assign lk.hs_valid = hs_valid_reg;
  assign lk.hs_code = hs_code_reg;
  assign lk.tx_valid = tx_valid_reg;
  assign lk.tx_byte = tx_byte_reg;
  assign lk.tx_end = tx_end_reg;
  assign lk.tx_data1 = tx_data1_reg;
  assign fw_rdata = fw_rdata_reg;
  assign irq = irq_reg;
endmodule : uep_device
`default_nettype wire

/* uep_pkg.sv */
// Purpose: Shared constants and types for the endpoint control block
// Assumes: 8-bit firmware register port, one clock domain
// Notes: Offsets are firmware byte addresses of the register window
package uep_pkg;
  // Firmware register addresses
  localparam logic [12:0] ADDR_CNT3 = 13'h1FCA;
  localparam logic [12:0] ADDR_CNT2 = 13'h1FCB;
  localparam logic [12:0] ADDR_CNT1 = 13'h1FCC;
  localparam logic [12:0] ADDR_CNT0 = 13'h1FCD;
  localparam logic [12:0] ADDR_CNT4 = 13'h1FCE;
  localparam logic [12:0] ADDR_EP0_STAT_CTRL = 13'h1FDD;
  localparam logic [12:0] ADDR_DATA3 = 13'h1FD2;
  localparam logic [12:0] ADDR_DATA2 = 13'h1FD3;
  localparam logic [12:0] ADDR_DATA1 = 13'h1FD4;
  localparam logic [12:0] ADDR_DATA0 = 13'h1FD5;
  localparam logic [12:0] ADDR_DATA4 = 13'h1FD6;
  // Endpoint zero control and status bit positions
  localparam int BIT_DIR = 7;
  localparam int BIT_LAST = 6;
  localparam int BIT_FSTALL = 5;
  localparam int BIT_LOADED = 4;
  localparam int BIT_STALL_SENT = 3;
  localparam int BIT_SETUP = 2;
  localparam int BIT_RX_OUT = 1;
  localparam int BIT_IN_DONE = 0;
  // Packet sizing
  localparam logic [6:0] CRC_BYTES = 7'h02;
  localparam logic [5:0] DEPTH_MASK_BIG = 6'h3F;
  localparam logic [5:0] DEPTH_MASK_SMALL = 6'h07;
  localparam logic [6:0] CNT_MASK_BIG = 7'h7F;
  localparam logic [6:0] CNT_MASK_SMALL = 7'h3F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Host controller APB offsets
  localparam logic [11:0] HOFS_CMD = 12'h000;
  localparam logic [11:0] HOFS_STATUS = 12'h004;
  localparam logic [11:0] HOFS_TXDATA = 12'h008;
  localparam logic [11:0] HOFS_RXDATA = 12'h00C;
  // Link token and handshake codes
  typedef enum logic [1:0] {TOK_SETUP, TOK_OUT, TOK_IN} uep_tok_t;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} uep_hs_t;
endpackage : uep_pkg

/* uep_link_if.sv */
// Purpose: Packet-level link between host controller and endpoint logic
// Assumes: Both ends clocked by the same pclk
// Notes: Data valid flags span the packet; token, end and handshake strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface uep_link_if;
  import uep_pkg::*;
  // Token from host
  logic tok_valid;
  uep_tok_t tok_kind;
  logic [2:0] tok_ep;
  // Data bytes from host
  logic dat_valid;
  logic [7:0] dat_byte;
  logic dat_end;
  // Handshake from device
  logic hs_valid;
  uep_hs_t hs_code;
  // Data bytes from device
  logic tx_valid;
  logic [7:0] tx_byte;
  logic tx_end;
  logic tx_data1;
  // Host handshake for device data
  logic hack_valid;
  logic hack_ok;
  modport dev (input tok_valid, tok_kind, tok_ep, dat_valid, dat_byte, dat_end,
    hack_valid, hack_ok, output hs_valid, hs_code, tx_valid, tx_byte, tx_end, tx_data1);
  modport host (output tok_valid, tok_kind, tok_ep, dat_valid, dat_byte, dat_end,
    hack_valid, hack_ok, input hs_valid, hs_code, tx_valid, tx_byte, tx_end, tx_data1);
endinterface : uep_link_if
`default_nettype wire

/* uep_host.sv */
// Purpose: Host-side transaction driver ordered over APB
// Assumes: APB master per AMBA, zero-wait answers from this slave
// Notes: One transaction at a time; CMD while busy is ignored
`timescale 1ns/1ps
`default_nettype none
module uep_host
  import uep_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to device
  uep_link_if.host lk
);
  typedef enum {H_IDLE, H_TOK, H_DATA, H_WAIT, H_ACK} uep_hstate_t;

  logic [7:0] tbuf [0:63]; // Bytes to send
  logic [7:0] rbuf [0:63]; // Bytes received
  uep_hstate_t state_reg;
  logic [6:0] len_reg, hi_reg, rc_reg;
  logic [5:0] tw_reg, rr_reg;
  logic noack_reg, got_hs_reg;
  uep_hs_t last_hs_reg;
  logic tok_valid_reg, dat_valid_reg, dat_end_reg, hack_valid_reg, hack_ok_reg;
  uep_tok_t kind_reg;
  logic [2:0] ep_reg;
  logic [7:0] dat_byte_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;

  // Access-phase write and read strobes
  logic acc, wr_cmd, wr_tx, rd_rx, mapped;
  always_comb
  begin
    acc = psel && penable && pready_reg;
    wr_cmd = acc && pwrite && paddr == HOFS_CMD && state_reg == H_IDLE;
    wr_tx = acc && pwrite && paddr == HOFS_TXDATA;
    rd_rx = acc && !pwrite && paddr == HOFS_RXDATA;
    mapped = paddr == HOFS_CMD || paddr == HOFS_STATUS || paddr == HOFS_TXDATA
      || paddr == HOFS_RXDATA;
  end

  // APB answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= psel && !penable;
      pslverr_reg <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite && paddr == HOFS_STATUS)
        prdata_reg <= {21'h000000, rc_reg, got_hs_reg, last_hs_reg, state_reg != H_IDLE};
      else if (psel && !penable && !pwrite && paddr == HOFS_RXDATA)
        prdata_reg <= {24'h000000, rbuf[rr_reg]};
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  // Transmit buffer from APB, receive from link
  always_ff @(posedge pclk)
  begin
    if (wr_tx)
      tbuf[tw_reg] <= pwdata[7:0];
    if (state_reg == H_WAIT && lk.tx_valid)
      rbuf[rc_reg[5:0]] <= lk.tx_byte;
  end

  // Buffer indices
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tw_reg <= 6'h00;
      rr_reg <= 6'h00;
    end
    else
    begin
      if (wr_cmd)
        tw_reg <= 6'h00;
      else if (wr_tx)
        tw_reg <= tw_reg + 6'h01;
      if (wr_cmd)
        rr_reg <= 6'h00;
      else if (rd_rx)
        rr_reg <= rr_reg + 6'h01;
    end
  end

  // Transaction sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= H_IDLE;
      len_reg <= 7'h00;
      hi_reg <= 7'h00;
      rc_reg <= 7'h00;
      noack_reg <= 1'b0;
      got_hs_reg <= 1'b0;
      last_hs_reg <= HS_ACK;
      tok_valid_reg <= 1'b0;
      dat_valid_reg <= 1'b0;
      dat_end_reg <= 1'b0;
      hack_valid_reg <= 1'b0;
      hack_ok_reg <= 1'b0;
      kind_reg <= TOK_SETUP;
      ep_reg <= 3'h0;
      dat_byte_reg <= 8'h00;
    end
    else
    begin
      tok_valid_reg <= 1'b0;
      dat_end_reg <= 1'b0;
      hack_valid_reg <= 1'b0;
      case (state_reg)
        H_IDLE:
        begin
          if (wr_cmd)
          begin
            kind_reg <= uep_tok_t'(pwdata[1:0]);
            ep_reg <= pwdata[4:2];
            len_reg <= pwdata[12:6];
            noack_reg <= pwdata[13];
            rc_reg <= 7'h00;
            tok_valid_reg <= 1'b1;
            state_reg <= H_TOK;
          end
        end
        H_TOK:
        begin
          if (kind_reg == TOK_IN)
            state_reg <= H_WAIT;
          else if (len_reg == 7'h00)
          begin
            dat_end_reg <= 1'b1;
            state_reg <= H_WAIT;
          end
          else
          begin
            dat_valid_reg <= 1'b1;
            dat_byte_reg <= tbuf[0];
            hi_reg <= 7'h01;
            state_reg <= H_DATA;
          end
        end
        H_DATA:
        begin
          if (hi_reg == len_reg)
          begin
            dat_valid_reg <= 1'b0;
            dat_end_reg <= 1'b1;
            state_reg <= H_WAIT;
          end
          else
          begin
            dat_byte_reg <= tbuf[hi_reg[5:0]];
            hi_reg <= hi_reg + 7'h01;
          end
        end
        H_WAIT:
        begin
          if (lk.tx_valid)
            rc_reg <= rc_reg + 7'h01;
          if (lk.hs_valid)
          begin
            last_hs_reg <= lk.hs_code;
            got_hs_reg <= 1'b1;
            state_reg <= H_IDLE;
          end
          else if (lk.tx_end)
          begin
            // Host's own handshake for the device packet
            got_hs_reg <= 1'b0;
            hack_valid_reg <= 1'b1;
            hack_ok_reg <= !noack_reg;
            state_reg <= H_ACK;
          end
        end
        H_ACK: state_reg <= H_IDLE;
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign lk.tok_valid = tok_valid_reg;
  assign lk.tok_kind = kind_reg;
  assign lk.tok_ep = ep_reg;
  assign lk.dat_valid = dat_valid_reg;
  assign lk.dat_byte = dat_byte_reg;
  assign lk.dat_end = dat_end_reg;
  assign lk.hack_valid = hack_valid_reg;
  assign lk.hack_ok = hack_ok_reg;
endmodule : uep_host
`default_nettype wire

/* uep_checker.sv */
// Purpose: Link protocol checks between the host and device ends
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Watches the link signals only, never firmware state
`timescale 1ns/1ps
`default_nettype none
module uep_checker
  import uep_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic tok_valid,
  input wire uep_tok_t tok_kind,
  input wire logic dat_end,
  input wire logic hs_valid,
  input wire uep_hs_t hs_code,
  input wire logic tx_valid,
  input wire logic tx_end,
  input wire logic tx_data1,
  input wire logic hack_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Last token was SETUP
  logic setup_reg;
  // SETUP accepted, no packet acknowledged yet
  logic fresh_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      setup_reg <= 1'b0;
    else if (tok_valid)
      setup_reg <= (tok_kind == TOK_SETUP);
  // First packet after SETUP carries DATA1
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      fresh_reg <= 1'b0;
    else if (hs_valid && setup_reg && hs_code == HS_ACK)
      fresh_reg <= 1'b1;
    else if (hack_valid)
      fresh_reg <= 1'b0;
  property p_hs_cause; hs_valid |-> $past(dat_end) || $past(tok_valid); endproperty
  a_hs_cause: assert property (p_hs_cause)
    else $error("handshake without token or packet end");
  property p_out_hs; dat_end |=> hs_valid; endproperty
  a_out_hs: assert property (p_out_hs)
    else $error("no handshake after data packet");
  property p_setup_ack; dat_end && setup_reg |=> hs_code == HS_ACK; endproperty
  a_setup_ack: assert property (p_setup_ack)
    else $error("setup packet not acknowledged");
  property p_hs_pulse; hs_valid |=> !hs_valid; endproperty
  a_hs_pulse: assert property (p_hs_pulse)
    else $error("handshake longer than one cycle");
  property p_in_answer;
    tok_valid && tok_kind == TOK_IN |=> hs_valid or ##1 (tx_valid || tx_end);
  endproperty
  a_in_answer: assert property (p_in_answer)
    else $error("in token left unanswered");
  property p_tx_cause; (tx_valid || tx_end) && !$past(tx_valid) |-> $past(tok_valid, 2); endproperty
  a_tx_cause: assert property (p_tx_cause)
    else $error("data sent without in token");
  property p_end_pulse; tx_end |=> !tx_end && !tx_valid; endproperty
  a_end_pulse: assert property (p_end_pulse)
    else $error("data after packet end");
  property p_fresh_data1; (tx_valid || tx_end) && fresh_reg |-> tx_data1; endproperty
  a_fresh_data1: assert property (p_fresh_data1)
    else $error("first packet after setup not data1");
endmodule : uep_checker
`default_nettype wire

/* usb_function_endpoint_control_test.sv */
// Purpose: Firmware and host traffic through both ends of the link
// Assumes: Host end ordered over APB, device registers by strobes
// Notes: Scenarios run in order; the fifo pointer carries over
`timescale 1ns/1ps
`default_nettype none
module usb_function_endpoint_control_test;
  import uep_pkg::*;
  // Bus, firmware port and bookkeeping
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, irq_en, fw_wr, fw_rd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic [12:0] fw_addr;
  logic [7:0] fw_wdata, fw_rdata;
  int err_total, n_tests, cyc;
  uep_link_if lk ();
  uep_device uep_device_inst (.pclk(pclk), .presetn(presetn), .lk(lk), .fw_addr(fw_addr),
    .fw_wr(fw_wr), .fw_rd(fw_rd), .fw_wdata(fw_wdata), .fw_rdata(fw_rdata),
    .irq_en(irq_en), .irq(irq));
  uep_host uep_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lk(lk));
  uep_checker uep_checker_inst (.pclk(pclk), .presetn(presetn), .tok_valid(lk.tok_valid),
    .tok_kind(lk.tok_kind), .dat_end(lk.dat_end), .hs_valid(lk.hs_valid),
    .hs_code(lk.hs_code), .tx_valid(lk.tx_valid), .tx_end(lk.tx_end),
    .tx_data1(lk.tx_data1), .hack_valid(lk.hack_valid));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard, far above run length
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      test_done();
    end
  end
  task automatic test_done;
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // APB transfer, held until pready is high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff (pready === 1'b1));
    st = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Firmware access; read checked a cycle later
  task automatic fw(input logic w, input logic [12:0] a, input logic [7:0] d, input logic [7:0] e);
    fw_addr <= a;
    fw_wdata <= d;
    fw_wr <= w;
    fw_rd <= !w;
    @(posedge pclk);
    fw_wr <= 1'b0;
    fw_rd <= 1'b0;
    @(posedge pclk);
    if (!w)
      chk("fw read", e, fw_rdata);
  endtask : fw
  // Host transaction on endpoint zero
  task automatic send(input uep_tok_t k, input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++)
      apb(1'b1, HOFS_TXDATA, {24'h0, b + 8'(i)});
    apb(1'b1, HOFS_CMD, {19'h0, 7'(n), 4'h0, k});
    do
      apb(1'b0, HOFS_STATUS, 32'h0);
    while (st[0] !== 1'b0);
  endtask : send
  task automatic drain(input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++)
      fw(1'b0, ADDR_DATA0, 8'h00, b + 8'(i));
  endtask : drain
  task automatic rs(input logic [7:0] e);
    fw(1'b0, ADDR_EP0_STAT_CTRL, 8'h00, e);
  endtask : rs
  task automatic wc(input logic [7:0] d);
    fw(1'b1, ADDR_EP0_STAT_CTRL, d, 8'h00);
  endtask : wc
  task automatic s_regs;
    rs(8'h00);
    fw(1'b1, ADDR_CNT1, 8'hFF, 8'h00);
    fw(1'b0, ADDR_CNT1, 8'h00, {1'b0, CNT_MASK_BIG});
    fw(1'b1, ADDR_CNT3, 8'hFF, 8'h00);
    fw(1'b0, ADDR_CNT3, 8'h00, {1'b0, CNT_MASK_SMALL});
  endtask : s_regs
  task automatic s_setup;
    send(TOK_SETUP, 8, 8'h30);
    chk("hs", HS_ACK, st[2:1]);
    rs(8'h04);
    chk("irq", 1, irq);
    fw(1'b0, ADDR_CNT0, 8'h00, 8'h0A);
    drain(8, 8'h30);
    wc(8'h04);
    rs(8'h00);
  endtask : s_setup
  // Control read; drain left pointer at zero
  task automatic s_in;
    for (int i = 0; i < 3; i++)
      fw(1'b1, ADDR_DATA0, 8'h50 + 8'(i), 8'h00);
    fw(1'b1, ADDR_CNT0, 8'h05, 8'h00);
    wc(8'h90);
    send(TOK_IN, 0, 8'h00);
    chk("len", 3, st[10:4]);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, HOFS_RXDATA, 32'h0);
      chk("rx", 8'h50 + 8'(i), st[7:0]);
    end
    rs(8'h01);
    wc(8'h81);
    rs(8'h00);
    send(TOK_IN, 0, 8'h00);
    chk("hs", HS_NAK, st[2:1]);
  endtask : s_in
  task automatic s_stall;
    wc(8'h20);
    send(TOK_OUT, 0, 8'h00);
    chk("hs", HS_STALL, st[2:1]);
    rs(8'h08);
    wc(8'h08);
    rs(8'h00);
  endtask : s_stall
  task automatic s_status;
    wc(8'h40);
    send(TOK_IN, 0, 8'h00);
    chk("zero len", 0, st[10:3]);
    rs(8'h01);
    wc(8'h01);
  endtask : s_status
  // OUT while data pends is refused
  task automatic s_out;
    send(TOK_OUT, 2, 8'h70);
    rs(8'h02);
    send(TOK_OUT, 2, 8'h90);
    chk("hs", HS_NAK, st[2:1]);
    drain(2, 8'h70);
    wc(8'h02);
    rs(8'h00);
  endtask : s_out
  initial
  begin
    {err_total, n_tests, cyc} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata, fw_wr, fw_rd, fw_addr, fw_wdata} = '0;
    irq_en = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_setup();
    s_in();
    s_stall();
    s_status();
    s_out();
    test_done();
  end
endmodule : usb_function_endpoint_control_test
`default_nettype wire
